// ===== rtl/apms_pkg.sv
package apms_pkg;

  // ----------------------------------------------------------------
  // Add-On register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_IN_MBOX = 7'h0c;
  localparam logic [6:0] OFS_OUT_MBOX = 7'h1c;
  localparam logic [6:0] OFS_PT_ADDR = 7'h28;
  localparam logic [6:0] OFS_PT_DATA = 7'h2c;
  localparam logic [6:0] OFS_FILL = 7'h34;

  // ----------------------------------------------------------------
  // Field layout of the fill status word
  // ----------------------------------------------------------------
  localparam int OUT_FILL_LSB = 28;
  localparam int OUT_FILL_MSB = 31;
  localparam int IN_FILL_LSB = 12;
  localparam int IN_FILL_MSB = 15;
  localparam logic [31:0] FILL_RESV_MASK = 32'h0fff0fff;

  // ----------------------------------------------------------------
  // Reset values, widths and steps
  // ----------------------------------------------------------------
  localparam logic [31:0] FILL_RESET = 32'h00000000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [31:0] ADDR_STEP = 32'h00000004;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Pass-through cycle state
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    APMS_IDLE = 3'b001,
    APMS_WRITE = 3'b010,
    APMS_READ = 3'b100
  } apms_state_t;

endpackage : apms_pkg

// ===== rtl/apms_fifo.sv
`timescale 1ns/100ps
module apms_fifo
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // Honest flags straight from the occupancy count
  assign in_ready = (count != CNT_FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer wrap is explicit so any depth works, not only powers of two
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
      next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
    if (pop)
      next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Data array has no reset; only valid entries are ever read out
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule : apms_fifo

// ===== rtl/apms_passthru_regs.sv
`timescale 1ns/100ps
module apms_passthru_regs
(
  input wire logic clk_sys,
  input wire logic reset_n,
  // Add-On register port
  input wire logic addon_select_n,
  input wire logic [3:0] addon_byte_lanes,
  input wire logic addon_rd_n,
  input wire logic addon_wr_n,
  input wire logic [6:0] addon_addr,
  input wire logic [31:0] addon_wdata,
  output logic [31:0] addon_rdata,
  // Pass-through side of the PCI target
  input wire logic passive_mode,
  input wire logic pci_pt_start,
  input wire logic pci_pt_write,
  input wire logic [31:0] pci_pt_addr,
  input wire logic pci_pt_end,
  input wire logic pci_wr_valid,
  input wire logic [31:0] pci_wr_data,
  output logic pci_wr_ready,
  input wire logic pci_rd_req,
  output logic [31:0] pci_rd_data,
  output logic pci_rd_valid,
  output logic pci_pt_wait,
  // Mailbox events seen on the PCI side
  input wire logic [3:0] pci_in_mbox_wr,
  input wire logic [3:0] pci_out_mbox_rd,
  output logic [31:0] host_view_fill_status
);

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic acc_sel;
  logic rd_acc, wr_acc;
  logic rd_pt_data, wr_pt_data;
  logic [3:0] addon_in_clr, addon_out_set;

  // A strobe counts only with select and at least one lane
  assign acc_sel = !addon_select_n
                   && (addon_byte_lanes != apms_pkg::LANES_NONE);
  assign rd_acc = acc_sel && !addon_rd_n;
  assign wr_acc = acc_sel && !addon_wr_n;
  assign rd_pt_data = rd_acc && (addon_addr == apms_pkg::OFS_PT_DATA);
  assign wr_pt_data = wr_acc && (addon_addr == apms_pkg::OFS_PT_DATA);

  // Mailbox lane events from the Add-On side
  assign addon_in_clr = (rd_acc && addon_addr == apms_pkg::OFS_IN_MBOX)
                        ? addon_byte_lanes : apms_pkg::LANES_NONE;
  assign addon_out_set = (wr_acc && addon_addr == apms_pkg::OFS_OUT_MBOX)
                         ? addon_byte_lanes : apms_pkg::LANES_NONE;

  // ----------------------------------------------------------------
  // Pass-through write buffer
  // ----------------------------------------------------------------
  logic fifo_in_valid, fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  apms_pkg::apms_state_t state, next_state;

  // Only data of an accepted write cycle enters the buffer
  assign fifo_in_valid = pci_wr_valid && (state == apms_pkg::APMS_WRITE);
  assign pci_wr_ready = fifo_in_ready && (state == apms_pkg::APMS_WRITE);

  apms_fifo
  #(
    .WIDTH (apms_pkg::DATA_W),
    .DEPTH (apms_pkg::FIFO_DEPTH)
  )
  u_wr_fifo
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .in_valid (fifo_in_valid),
    .in_ready (fifo_in_ready),
    .in_data (pci_wr_data),
    .out_valid (fifo_out_valid),
    .out_ready (rd_pt_data),
    .out_data (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Cycle state and captured address
  // ----------------------------------------------------------------
  logic [31:0] pt_addr, next_pt_addr;
  logic wr_xfer_done, rd_xfer_done;
  logic [31:0] next_rd_data;
  logic next_rd_valid;

  // A write transfer completes when the Add-On pops a buffered word
  assign wr_xfer_done = rd_pt_data && fifo_out_valid;
  // A read transfer completes when the Add-On supplies the word
  assign rd_xfer_done = wr_pt_data && (state == apms_pkg::APMS_READ)
                        && pci_rd_req && !pci_rd_valid;

  // New cycle capture beats the increment of a stale one
  always_comb
  begin
    next_state = state;
    next_pt_addr = pt_addr;
    next_rd_data = pci_rd_data;
    next_rd_valid = 1'b0;
    if (pci_pt_start)
    begin
      next_state = pci_pt_write ? apms_pkg::APMS_WRITE
                                : apms_pkg::APMS_READ;
      next_pt_addr = pci_pt_addr;
    end
    else
    begin
      if (pci_pt_end)
        next_state = apms_pkg::APMS_IDLE;
      if (wr_xfer_done || rd_xfer_done)
        next_pt_addr = pt_addr + apms_pkg::ADDR_STEP;
    end
    if (rd_xfer_done)
    begin
      next_rd_data = addon_wdata;
      next_rd_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= apms_pkg::APMS_IDLE;
      pt_addr <= apms_pkg::WORD_RESET;
      pci_rd_data <= apms_pkg::WORD_RESET;
      pci_rd_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pt_addr <= next_pt_addr;
      pci_rd_data <= next_rd_data;
      pci_rd_valid <= next_rd_valid;
    end
  end

  // Waits only in passive mode; active-mode pacing lives elsewhere
  assign pci_pt_wait = passive_mode &&
    (((state == apms_pkg::APMS_WRITE) && pci_wr_valid && !fifo_in_ready)
     || ((state == apms_pkg::APMS_READ) && pci_rd_req
         && !pci_rd_valid));

  // ----------------------------------------------------------------
  // Mailbox byte fill flags
  // ----------------------------------------------------------------
  logic [3:0] in_fill, next_in_fill;
  logic [3:0] out_fill, next_out_fill;

  // Set beats clear so a write landing with a read is never lost
  always_comb
  begin
    next_in_fill = (in_fill & ~addon_in_clr) | pci_in_mbox_wr;
    next_out_fill = (out_fill & ~pci_out_mbox_rd) | addon_out_set;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_fill <= apms_pkg::LANES_NONE;
      out_fill <= apms_pkg::LANES_NONE;
    end
    else
    begin
      in_fill <= next_in_fill;
      out_fill <= next_out_fill;
    end
  end

  // Status word built from flops; reserved bits stay zero
  always_comb
  begin
    host_view_fill_status = apms_pkg::FILL_RESET;
    host_view_fill_status[apms_pkg::OUT_FILL_MSB:apms_pkg::OUT_FILL_LSB] =
      out_fill;
    host_view_fill_status[apms_pkg::IN_FILL_MSB:apms_pkg::IN_FILL_LSB] =
      in_fill;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  // Unmapped offsets answer zero; the word holds until the next read
  always_comb
  begin
    next_rdata = addon_rdata;
    if (rd_acc)
    begin
      if (addon_addr == apms_pkg::OFS_PT_ADDR)
        next_rdata = pt_addr;
      else if (addon_addr == apms_pkg::OFS_PT_DATA)
        next_rdata = fifo_out_valid ? fifo_out_data
                                    : apms_pkg::WORD_RESET;
      else if (addon_addr == apms_pkg::OFS_FILL)
        next_rdata = host_view_fill_status;
      else
        next_rdata = apms_pkg::WORD_RESET;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      addon_rdata <= apms_pkg::WORD_RESET;
    else
      addon_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence pt_rd_pending;
    passive_mode && (state == apms_pkg::APMS_READ) && pci_rd_req
    && !pci_rd_valid && !pci_pt_start && !pci_pt_end;
  endsequence

  sequence pt_rd_served;
    wr_pt_data && pci_rd_req && !pci_pt_start;
  endsequence

  sequence fill_read;
    rd_acc && (addon_addr == apms_pkg::OFS_FILL);
  endsequence

  capture_addr_a: assert property (pci_pt_start |=>
    pt_addr == $past(pci_pt_addr))
    else $error("Pass-through address not captured");

  addr_step_a: assert property (!pci_pt_start && wr_xfer_done |=>
    pt_addr == $past(pt_addr) + apms_pkg::ADDR_STEP)
    else $error("Address did not advance by one word");

  wr_data_out_a: assert property (wr_xfer_done |=>
    addon_rdata == $past(fifo_out_data))
    else $error("Data port did not show PCI write data");

  wait_write_a: assert property (passive_mode
    && (state == apms_pkg::APMS_WRITE) && pci_wr_valid && !fifo_in_ready
    |-> pci_pt_wait)
    else $error("No wait state while write buffer full");

  wait_read_a: assert property (pt_rd_pending |-> pci_pt_wait)
    else $error("No wait state while read data pending");

  // Wait must drop once the Add-On side has served the read
  rd_return_a: assert property (pt_rd_pending and pt_rd_served |=>
    pci_rd_valid && !pci_pt_wait
    && pci_rd_data == $past(addon_wdata))
    else $error("Read data not returned after data port write");

  out_field_a: assert property (fill_read |=>
    addon_rdata[apms_pkg::OUT_FILL_MSB:apms_pkg::OUT_FILL_LSB]
    == $past(out_fill))
    else $error("Outgoing status field misplaced");

  in_field_a: assert property (fill_read |=>
    addon_rdata[apms_pkg::IN_FILL_MSB:apms_pkg::IN_FILL_LSB]
    == $past(in_fill))
    else $error("Incoming status field misplaced");

  fill_set_a: assert property (pci_in_mbox_wr != apms_pkg::LANES_NONE |=>
    (in_fill & $past(pci_in_mbox_wr)) == $past(pci_in_mbox_wr))
    else $error("Incoming byte not marked full");

  fill_clear_a: assert property (pci_out_mbox_rd != apms_pkg::LANES_NONE
    && addon_out_set == apms_pkg::LANES_NONE |=>
    (out_fill & $past(pci_out_mbox_rd)) == apms_pkg::LANES_NONE)
    else $error("Outgoing byte not emptied by read");

  mbox_dir_a: assert property (1'b1 |=>
    (out_fill & ~$past(out_fill) & ~$past(addon_out_set))
    == apms_pkg::LANES_NONE
    && (in_fill & ~$past(in_fill) & ~$past(pci_in_mbox_wr))
    == apms_pkg::LANES_NONE)
    else $error("Mailbox filled from the wrong side");

  // Without a qualified strobe or a cycle start neither read data nor address may move
  strobe_qual_a: assert property (!rd_acc && !wr_acc && !pci_pt_start
    |=> $stable(addon_rdata) && $stable(pt_addr))
    else $error("State moved without a qualified strobe");

  resv_zero_a: assert property (fill_read |=>
    (addon_rdata & apms_pkg::FILL_RESV_MASK) == apms_pkg::WORD_RESET)
    else $error("Reserved status bits not zero");

endmodule : apms_passthru_regs

// ===== sim/apms_pci_model.sv
`timescale 1ns/100ps
// ----
// PCI side stand-in
// ----
module apms_pci_model
(
  input wire logic clk_sys,
  output logic pci_pt_start,
  output logic pci_pt_write,
  output logic [31:0] pci_pt_addr,
  output logic pci_pt_end,
  output logic pci_wr_valid,
  output logic [31:0] pci_wr_data,
  input wire logic pci_wr_ready,
  output logic pci_rd_req,
  output logic [3:0] pci_in_mbox_wr,
  output logic [3:0] pci_out_mbox_rd
);
  logic [31:0] wq[$];

  // Idle levels at time zero
  initial
  begin
    {pci_pt_start, pci_pt_write, pci_pt_end, pci_rd_req} = 4'h0;
    {pci_in_mbox_wr, pci_out_mbox_rd} = 8'h00;
    pci_pt_addr = 32'h00000000;
    pci_wr_valid = 1'b0;
    pci_wr_data = 32'h00000000;
  end

  // Head of queue offered; idle data toggles so stale words never match
  always @(negedge clk_sys)
  begin
    pci_wr_valid <= (wq.size() > 0);
    pci_wr_data <= (wq.size() > 0) ? wq[0] : ~pci_wr_data;
  end

  // Ready is read before the edge's updates land
  always @(posedge clk_sys)
    if (pci_wr_valid && pci_wr_ready && wq.size() > 0)
      void'(wq.pop_front());

  // Accepted region hit, one cycle
  task automatic start(input logic w, input logic [31:0] a);
    @(negedge clk_sys);
    pci_pt_start = 1'b1;
    pci_pt_write = w;
    pci_pt_addr = a;
    @(negedge clk_sys);
    pci_pt_start = 1'b0;
    pci_pt_addr = ~a;
  endtask : start

  // Master read request level, held until the caller drops it
  task automatic request(input logic r);
    pci_rd_req = r;
  endtask : request

  // Cycle end and mailbox byte events, one cycle each
  task automatic pulse(input logic e, input logic [3:0] i, input logic [3:0] o);
    @(negedge clk_sys);
    pci_pt_end = e;
    pci_in_mbox_wr = i;
    pci_out_mbox_rd = o;
    @(negedge clk_sys);
    pci_pt_end = 1'b0;
    pci_in_mbox_wr = 4'h0;
    pci_out_mbox_rd = 4'h0;
  endtask : pulse
endmodule : apms_pci_model

// ===== sim/addon_passthru_mailbox_status_tb.sv
`timescale 1ns/100ps
module addon_passthru_mailbox_status_tb;
  logic clk_sys, reset_n, addon_select_n, addon_rd_n, addon_wr_n;
  logic [3:0] addon_byte_lanes, pci_in_mbox_wr, pci_out_mbox_rd;
  logic [6:0] addon_addr;
  logic [31:0] addon_wdata, addon_rdata, pci_pt_addr, pci_wr_data;
  logic [31:0] pci_rd_data, host_view_fill_status, v;
  logic passive_mode, pci_pt_start, pci_pt_write, pci_pt_end;
  logic pci_wr_valid, pci_wr_ready, pci_rd_req, pci_rd_valid, pci_pt_wait;
  int error_cnt = 0;
  int check_count = 0;

  apms_passthru_regs dut
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .addon_select_n (addon_select_n),
    .addon_byte_lanes (addon_byte_lanes),
    .addon_rd_n (addon_rd_n),
    .addon_wr_n (addon_wr_n),
    .addon_addr (addon_addr),
    .addon_wdata (addon_wdata),
    .addon_rdata (addon_rdata),
    .passive_mode (passive_mode),
    .pci_pt_start (pci_pt_start),
    .pci_pt_write (pci_pt_write),
    .pci_pt_addr (pci_pt_addr),
    .pci_pt_end (pci_pt_end),
    .pci_wr_valid (pci_wr_valid),
    .pci_wr_data (pci_wr_data),
    .pci_wr_ready (pci_wr_ready),
    .pci_rd_req (pci_rd_req),
    .pci_rd_data (pci_rd_data),
    .pci_rd_valid (pci_rd_valid),
    .pci_pt_wait (pci_pt_wait),
    .pci_in_mbox_wr (pci_in_mbox_wr),
    .pci_out_mbox_rd (pci_out_mbox_rd),
    .host_view_fill_status (host_view_fill_status)
  );

  apms_pci_model pci
  (
    .clk_sys (clk_sys),
    .pci_pt_start (pci_pt_start),
    .pci_pt_write (pci_pt_write),
    .pci_pt_addr (pci_pt_addr),
    .pci_pt_end (pci_pt_end),
    .pci_wr_valid (pci_wr_valid),
    .pci_wr_data (pci_wr_data),
    .pci_wr_ready (pci_wr_ready),
    .pci_rd_req (pci_rd_req),
    .pci_in_mbox_wr (pci_in_mbox_wr),
    .pci_out_mbox_rd (pci_out_mbox_rd)
  );

  // ----
  // Clock and shared tasks
  // ----
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // One strobe cycle; read data is registered, so taken at the release
  task automatic acc(input logic w, input logic [6:0] a,
                     input logic [31:0] d, input logic [3:0] ln);
    @(negedge clk_sys);
    addon_select_n = 1'b0;
    addon_byte_lanes = ln;
    addon_addr = a;
    addon_wdata = d;
    addon_rd_n = w;
    addon_wr_n = !w;
    @(negedge clk_sys);
    {addon_select_n, addon_rd_n, addon_wr_n} = 3'b111;
    addon_byte_lanes = 4'h0;
    addon_wdata = ~d;
    v = addon_rdata;
  endtask : acc

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    acc(1'b0, 7'h34, 32'h00000000, 4'hf);
    chk(v, 32'h00000000);
    chk(host_view_fill_status, 32'h00000000);
    $display("test reset done");
  endtask : t_reset

  // Nine words against an eight deep buffer, then drained word by word
  task automatic t_write;
    int n;
    pci.start(1'b1, 32'h00001000);
    for (int i = 0; i < 9; i++)
      pci.wq.push_back(32'h000000d0 + i);
    for (n = 0; n < 30 && pci.wq.size() > 1; n++)
      @(negedge clk_sys);
    if (n == 30)
    begin
      chk(1'b0, 1'b1);
      give_verdict();
    end
    chk(pci_wr_ready, 32'h0);
    chk(pci_pt_wait, 32'h1);
    acc(1'b0, 7'h28, 32'h0, 4'hf);
    chk(v, 32'h00001000);
    for (int i = 0; i < 9; i++)
    begin
      acc(1'b0, 7'h2c, 32'h0, 4'hf);
      chk(v, 32'h000000d0 + i);
      acc(1'b0, 7'h28, 32'h0, 4'hf);
      chk(v, 32'h00001000 + 4 * (i + 1));
    end
    chk(pci_pt_wait, 32'h0);
    acc(1'b0, 7'h2c, 32'h0, 4'hf);
    chk(v, 32'h00000000);
    acc(1'b1, 7'h28, 32'hffffffff, 4'hf);
    acc(1'b0, 7'h28, 32'h0, 4'hf);
    chk(v, 32'h00001024);
    pci.pulse(1'b1, 4'h0, 4'h0);
    $display("test write done");
  endtask : t_write

  // Master waits until the data port is written
  task automatic t_read;
    pci.start(1'b0, 32'h00002000);
    pci.request(1'b1);
    @(negedge clk_sys);
    chk(pci_pt_wait, 32'h1);
    passive_mode = 1'b0;
    #1 chk(pci_pt_wait, 32'h0);
    passive_mode = 1'b1;
    acc(1'b1, 7'h2c, 32'h5a5a1234, 4'hf);
    chk(pci_rd_valid, 32'h1);
    chk(pci_rd_data, 32'h5a5a1234);
    pci.request(1'b0);
    acc(1'b1, 7'h2c, 32'h11112222, 4'hf);
    chk(pci_rd_valid, 32'h0);
    acc(1'b0, 7'h28, 32'h0, 4'hf);
    chk(v, 32'h00002004);
    pci.pulse(1'b1, 4'h0, 4'h0);
    $display("test read done");
  endtask : t_read

  // Byte flags set by the source side, cleared by the destination
  task automatic t_mbox;
    pci.pulse(1'b0, 4'h5, 4'h0);
    acc(1'b0, 7'h34, 32'h0, 4'hf);
    chk(v, 32'h00005000);
    acc(1'b0, 7'h0c, 32'h0, 4'h1);
    acc(1'b0, 7'h34, 32'h0, 4'hf);
    chk(v, 32'h00004000);
    acc(1'b1, 7'h1c, 32'h0, 4'ha);
    acc(1'b0, 7'h34, 32'h0, 4'hf);
    chk(v, 32'ha0004000);
    pci.pulse(1'b0, 4'h0, 4'h2);
    acc(1'b0, 7'h0c, 32'h0, 4'h0);
    acc(1'b0, 7'h34, 32'h0, 4'hf);
    chk(v, 32'h80004000);
    acc(1'b1, 7'h34, 32'hffffffff, 4'hf);
    acc(1'b0, 7'h34, 32'h0, 4'hf);
    chk(v, 32'h80004000);
    chk(host_view_fill_status, 32'h80004000);
    $display("test mailbox done");
  endtask : t_mbox

  // Main sequence; reset held six cycles
  initial
  begin
    {addon_select_n, addon_rd_n, addon_wr_n} = 3'b111;
    addon_byte_lanes = 4'h0;
    addon_addr = 7'h00;
    addon_wdata = 32'h00000000;
    passive_mode = 1'b1;
    reset_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    t_reset();
    t_write();
    t_read();
    t_mbox();
    give_verdict();
  end
endmodule : addon_passthru_mailbox_status_tb
